/* core/angle_sensor_pkg.sv */
// Summary of operation
// R1: Angle register at address 0x00, 12 bits, readable in both modes.
// R2: Angle code n means n*360/4096 degrees, 0x000 to 0xFFF.
// R3: Angle register holds the hysteresis-filtered angle.
// R4: Flux register at 0x01, user-mode read only, about 1 code per mT.
// R5: Flux is a 7-bit field, 0 to 127 mT, reference only.
// R6: Mode register 0x02 changes only by the mode-change opcode.
// R7: Mode 0x000 is normal and reset default, 0x50F is user.
// R8: Fault monitor at 0x03 is user-mode read only.
// R9: Fault bit 1 flux, bit 0 tracking; 0 means fault present.
// R10: Addresses 0x04 and 0x05 are never readable or writable.
// R11: Zero point at 0x06, user-mode read-write, default 0x000.
// R12: Zero point offset is applied to ABZ and UVW outputs.
// R13: Zero point reloads from memory at power-on and user-to-normal.
// R14: 0x07, 0x09, 0x0A user read-write; 0x08 user read-only lock.
// R15: Opcodes: 0011 write, 0100 read, 0101 mode change, frame start.
// R16: Opcode, address and data travel MSB first both ways.
// R17: Writes not allowed in current mode leave registers unchanged.
// R18: Reads of unavailable addresses return no meaningful data.
package angle_sensor_pkg;

	localparam int DATA_W = 12;
	localparam int ADDR_W = 7;
	localparam int OP_W = 4;
	localparam int FLUX_W = 7;

	localparam logic [ADDR_W-1:0] ADDR_ANGLE = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_FLUX = 7'h01;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_FAULT = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_INC = 7'h07;
	localparam logic [ADDR_W-1:0] ADDR_LOCK = 7'h08;
	localparam logic [ADDR_W-1:0] ADDR_DIS = 7'h09;
	localparam logic [ADDR_W-1:0] ADDR_UVW = 7'h0A;

	localparam logic [OP_W-1:0] OP_WRITE = 4'h3;
	localparam logic [OP_W-1:0] OP_READ = 4'h4;
	localparam logic [OP_W-1:0] OP_MODE = 4'h5;

	localparam logic [DATA_W-1:0] MODE_NORMAL = 12'h000;
	localparam logic [DATA_W-1:0] MODE_USER = 12'h50F;

	localparam logic [DATA_W-1:0] RST_MODE = 12'h000;
	localparam logic [DATA_W-1:0] RST_ZERO = 12'h000;
	localparam logic [DATA_W-1:0] RST_INC = 12'h0A0;
	localparam logic [DATA_W-1:0] RST_DIS = 12'h000;
	localparam logic [DATA_W-1:0] RST_UVW = 12'h052;
	localparam logic [DATA_W-1:0] RST_LOCK = 12'h003;

	localparam int INC_HYS_LSB = 4;
	localparam int DIS_FLUX_BIT = 1;
	localparam int DIS_TRACK_BIT = 0;

	// Bit counts within a frame, counted on rising link clock edges
	localparam logic [4:0] CNT_ADDR_LAST = 5'h0A;
	localparam logic [4:0] CNT_DATA_START = 5'h0C;
	localparam logic [4:0] CNT_FRAME_LAST = 5'h17;
	localparam logic [4:0] CNT_MAX = 5'h18;

endpackage

/* core/angle_sensor_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_register_bank (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] angle_raw_i,
	input wire logic [angle_sensor_pkg::FLUX_W-1:0] flux_raw_i,
	input wire logic flux_fault_i,
	input wire logic track_loss_i,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] nvm_zero_point_i,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] nvm_inc_cfg_i,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] nvm_dis_i,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] nvm_uvw_i,
	input wire logic [angle_sensor_pkg::DATA_W-1:0] nvm_lock_i,
	output logic [angle_sensor_pkg::DATA_W-1:0] angle_o,
	output logic [angle_sensor_pkg::DATA_W-1:0] position_o,
	output logic user_mode_o,
	output logic [angle_sensor_pkg::DATA_W-1:0] zero_point_offset_o,
	output logic [angle_sensor_pkg::DATA_W-1:0] incremental_output_config_o,
	output logic [angle_sensor_pkg::DATA_W-1:0] commutation_output_config_o,
	output logic [angle_sensor_pkg::DATA_W-1:0] fault_detect_disable_o
);
	import angle_sensor_pkg::*;

	// Threshold of wrap distance before the filtered angle follows
	function automatic logic [DATA_W-1:0] hys_thr(
		input logic [2:0] code
	);
		logic [DATA_W-1:0] t;
		t = 12'h002;
		unique case (code)
			3'h0: t = 12'h000;
			3'h1: t = 12'h001;
			3'h3: t = 12'h003;
			3'h4: t = 12'h004;
			default: t = 12'h002;
		endcase
		return t;
	endfunction

	function automatic logic [DATA_W-1:0] wrap_dist(
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		logic [DATA_W-1:0] d;
		d = a - b;
		if (d[DATA_W-1]) begin
			d = b - a;
		end
		return d;
	endfunction

	// ---------------- Link clock domain ----------------
	logic [4:0] bit_cnt_q;
	logic [22:0] in_sr_q;
	logic [OP_W-1:0] rd_op_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic rd_tgl_q;
	logic [OP_W-1:0] wr_op_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;
	logic wr_tgl_q;
	logic [DATA_W-1:0] out_sr_q;
	logic oe_n_q;

	// Frame position; chip select high restarts the frame
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt_q <= 5'h00;
		end else if (bit_cnt_q != CNT_MAX) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			in_sr_q <= 23'h00_0000;
		end else begin
			in_sr_q <= {in_sr_q[21:0], mosi_i}; // R16
		end
	end

	// Read request: opcode and address held until the next request
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_op_q <= 4'h0;
			rd_addr_q <= 7'h00;
			rd_tgl_q <= 1'b0;
		end else if (!cs_n_i && bit_cnt_q == CNT_ADDR_LAST) begin
			rd_op_q <= in_sr_q[9:6]; // R15
			rd_addr_q <= {in_sr_q[5:0], mosi_i}; // R16
			if (in_sr_q[9:6] == OP_READ) begin
				rd_tgl_q <= ~rd_tgl_q;
			end
		end
	end

	// Write request taken only when the whole frame arrived
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_op_q <= 4'h0;
			wr_addr_q <= 7'h00;
			wr_data_q <= 12'h000;
			wr_tgl_q <= 1'b0;
		end else if (!cs_n_i && bit_cnt_q == CNT_FRAME_LAST) begin
			wr_op_q <= in_sr_q[22:19]; // R15
			wr_addr_q <= in_sr_q[18:12];
			wr_data_q <= {in_sr_q[10:0], mosi_i}; // R16
			if (in_sr_q[22:19] == OP_WRITE || in_sr_q[22:19] == OP_MODE) begin
				wr_tgl_q <= ~wr_tgl_q;
			end
		end
	end

	logic [DATA_W-1:0] rd_word_q;

	// Output changes on falling edges so the host samples on rising
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			out_sr_q <= 12'h000;
			oe_n_q <= 1'b1;
		end else if (bit_cnt_q == CNT_DATA_START) begin
			// Answer word held stable by the system side since request
			out_sr_q <= rd_word_q;
			oe_n_q <= (rd_op_q != OP_READ);
		end else begin
			out_sr_q <= {out_sr_q[DATA_W-2:0], 1'b0}; // R16
		end
	end

	assign miso_o = out_sr_q[DATA_W-1];
	assign miso_oe_n_o = oe_n_q;

	// ---------------- System clock domain ----------------
	logic rd_s1_q;
	logic rd_s2_q;
	logic rd_s3_q;
	logic wr_s1_q;
	logic wr_s2_q;
	logic wr_s3_q;
	logic rd_evt;
	logic wr_evt;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_s1_q <= 1'b0;
			rd_s2_q <= 1'b0;
			rd_s3_q <= 1'b0;
		end else begin
			rd_s1_q <= rd_tgl_q;
			rd_s2_q <= rd_s1_q;
			rd_s3_q <= rd_s2_q;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_s1_q <= 1'b0;
			wr_s2_q <= 1'b0;
			wr_s3_q <= 1'b0;
		end else begin
			wr_s1_q <= wr_tgl_q;
			wr_s2_q <= wr_s1_q;
			wr_s3_q <= wr_s2_q;
		end
	end

	assign rd_evt = rd_s2_q ^ rd_s3_q;
	assign wr_evt = wr_s2_q ^ wr_s3_q;

	logic [DATA_W-1:0] mode_q;
	logic [DATA_W-1:0] mode_d;
	logic user;
	logic reload_q;
	logic reload;
	logic wr_reg;

	assign user = (mode_q == MODE_USER);

	// Pin copy from a flop; follows mode_d so it never lags the decode
	logic user_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			user_q <= 1'b0;
		end else begin
			user_q <= (mode_d == MODE_USER);
		end
	end

	// Mode register writable only through the mode-change opcode
	always_comb begin
		mode_d = mode_q;
		if (wr_evt && wr_op_q == OP_MODE && wr_addr_q == ADDR_MODE) begin // R6
			if (wr_data_q == MODE_USER || wr_data_q == MODE_NORMAL) begin // R7
				mode_d = wr_data_q;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= RST_MODE; // R7
		end else begin
			mode_q <= mode_d;
		end
	end

	// Power-on load happens on the first edge after reset release
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reload_q <= 1'b1;
		end else begin
			reload_q <= 1'b0;
		end
	end

	assign reload = reload_q || (user && mode_d == MODE_NORMAL); // R13
	assign wr_reg = wr_evt && wr_op_q == OP_WRITE && user; // R17

	logic [DATA_W-1:0] zero_q;
	logic [DATA_W-1:0] inc_q;
	logic [DATA_W-1:0] dis_q;
	logic [DATA_W-1:0] uvw_q;
	logic [DATA_W-1:0] lock_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			zero_q <= RST_ZERO; // R11
		end else if (reload) begin
			zero_q <= nvm_zero_point_i; // R13
		end else if (wr_reg && wr_addr_q == ADDR_ZERO) begin
			zero_q <= wr_data_q; // R11
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			inc_q <= RST_INC;
			dis_q <= RST_DIS;
			uvw_q <= RST_UVW;
			lock_q <= RST_LOCK;
		end else if (reload) begin
			inc_q <= nvm_inc_cfg_i;
			dis_q <= nvm_dis_i;
			uvw_q <= nvm_uvw_i;
			lock_q <= nvm_lock_i;
		end else if (wr_reg) begin
			// Lock status is read only, so it has no write path
			if (wr_addr_q == ADDR_INC) begin
				inc_q <= wr_data_q; // R14
			end
			if (wr_addr_q == ADDR_DIS) begin
				dis_q <= wr_data_q; // R14
			end
			if (wr_addr_q == ADDR_UVW) begin
				uvw_q <= wr_data_q; // R14
			end
		end
	end

	// Filtered angle: a one-code dither reaches ABZ or readback only when the hysteresis code is 0
	logic [DATA_W-1:0] angle_q;
	logic [DATA_W-1:0] thr;

	assign thr = hys_thr(inc_q[INC_HYS_LSB +: 3]);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			angle_q <= 12'h000;
		end else if (wrap_dist(angle_raw_i, angle_q) > thr) begin
			angle_q <= angle_raw_i; // R3
		end
	end

	logic [FLUX_W-1:0] flux_q;
	logic [1:0] fault_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			flux_q <= 7'h00;
			fault_q <= 2'h3;
		end else begin
			flux_q <= flux_raw_i; // R5
			fault_q[1] <= ~(flux_fault_i & ~dis_q[DIS_FLUX_BIT]); // R9
			fault_q[0] <= ~(track_loss_i & ~dis_q[DIS_TRACK_BIT]); // R9
		end
	end

	// Read answer; unavailable addresses answer zero
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = 12'h000; // R18
		if (rd_addr_q == ADDR_ANGLE) begin
			rd_mux = angle_q; // R1
		end else if (user) begin
			unique case (rd_addr_q)
				ADDR_FLUX: rd_mux = {5'h00, flux_q}; // R4
				ADDR_MODE: rd_mux = mode_q; // R6
				ADDR_FAULT: rd_mux = {10'h000, fault_q}; // R8
				ADDR_ZERO: rd_mux = zero_q; // R11
				ADDR_INC: rd_mux = inc_q; // R14
				ADDR_LOCK: rd_mux = lock_q; // R14
				ADDR_DIS: rd_mux = dis_q; // R14
				ADDR_UVW: rd_mux = uvw_q; // R14
				default: rd_mux = 12'h000; // R10
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_word_q <= 12'h000;
		end else if (rd_evt) begin
			rd_word_q <= rd_mux;
		end
	end

	// Zero-referenced position feeds the pulse generators
	logic [DATA_W-1:0] pos_q;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pos_q <= 12'h000;
		end else begin
			pos_q <= angle_q - zero_q; // R12
		end
	end

	assign angle_o = angle_q; // R2
	assign position_o = pos_q;
	assign user_mode_o = user_q;
	assign zero_point_offset_o = zero_q;
	assign incremental_output_config_o = inc_q;
	assign commutation_output_config_o = uvw_q;
	assign fault_detect_disable_o = dis_q;

endmodule
`default_nettype wire

/* testbench/angle_sensor_register_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_register_bank_sva
	import angle_sensor_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic miso_o,
	input wire logic miso_oe_n_o,
	input wire logic [DATA_W-1:0] nvm_zero_point_i,
	input wire logic [DATA_W-1:0] angle_o,
	input wire logic [DATA_W-1:0] position_o,
	input wire logic user_mode_o,
	input wire logic [DATA_W-1:0] zero_point_offset_o,
	input wire logic [DATA_W-1:0] incremental_output_config_o
);
	logic [3:0] idle_q;
	logic [4:0] bit_q;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			idle_q <= 4'h0;
		end else if (!cs_n_i) begin
			idle_q <= 4'h0;
		end else if (idle_q != 4'hF) begin
			idle_q <= idle_q + 4'h1;
		end
	end
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) bit_q <= 5'h00;
		else if (bit_q != 5'h1F) bit_q <= bit_q + 5'h01;
	end
	AST_OE_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cs_n_i [*2] |-> miso_oe_n_o && !miso_o) else $error("miso driven outside frame");
	AST_OE_LATE: assert property (@(posedge sclk_i) disable iff (rst_i || cs_n_i)
		!miso_oe_n_o |-> bit_q >= 5'h0C) else $error("miso enabled before data phase");
	AST_OE_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!miso_oe_n_o && !cs_n_i ##1 !cs_n_i |-> !miso_oe_n_o) else $error("miso enable dropped");
	AST_POS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!$past(rst_i) |-> position_o == $past(angle_o) - $past(zero_point_offset_o))
		else $error("position not offset by zero point");
	AST_RELOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$fell(user_mode_o) |-> zero_point_offset_o == nvm_zero_point_i) else $error("no reload");
	AST_HOLD_NORMAL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!user_mode_o && !$past(user_mode_o) && !$past(rst_i) && !$past(rst_i, 2)
		|-> $stable({zero_point_offset_o, incremental_output_config_o}))
		else $error("config changed in normal mode");
	AST_MODE_WIN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(user_mode_o) |-> idle_q < 4'h8) else $error("mode changed without frame");
	AST_ZERO_WIN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(zero_point_offset_o) && !$past(rst_i) |-> idle_q < 4'h8)
		else $error("zero point changed without frame");
endmodule
bind angle_sensor_register_bank angle_sensor_register_bank_sva u_sva (.clk_sys_i, .rst_i,
	.sclk_i, .cs_n_i, .miso_o, .miso_oe_n_o, .nvm_zero_point_i, .angle_o, .position_o,
	.user_mode_o, .zero_point_offset_o, .incremental_output_config_o);
`default_nettype wire

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_n_i,
	output logic [11:0] word_o,
	output logic done_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		word_o = 12'h000;
		done_o = 1'b0;
	end
	// Clock stands still between frames; stale data flips so it never passes
	task automatic xfer(input logic [3:0] op, input logic [6:0] a, input logic [11:0] d);
		logic [23:0] sh;
		sh = {op, a, 1'b0, d};
		#13 cs_n_o = 1'b0;
		for (int i = 0; i < 25; i++) begin
			mosi_o = (i < 24) ? sh[23-i] : ~mosi_o;
			#80 sclk_o = 1'b1;
			if (i > 11 && i < 24) word_o = {word_o[10:0], miso_oe_n_i ? ~miso_i : miso_i};
			#80 sclk_o = 1'b0;
		end
		mosi_o = ~mosi_o;
		cs_n_o = 1'b1;
		if (op == 4'h4) done_o = ~done_o;
		#160;
	endtask
endmodule
`default_nettype wire

/* testbench/tb_angle_sensor_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_angle_sensor_register_bank;
	import angle_sensor_pkg::*;
	logic clk_sys_i, rst_i, sclk, cs_n, mosi, miso, oe_n, done, flux_flt, trk_loss, um;
	logic [DATA_W-1:0] ang_raw, nvm_zp, word, zp, ang, d, tmp, inc_cfg, uvw_cfg, dis_cfg;
	logic [FLUX_W-1:0] flux;
	logic [DATA_W-1:0] exp_q[$];
	int error_cnt, tests_run, seed;
	spi_host_model u_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_n_i(oe_n), .word_o(word), .done_o(done));
	angle_sensor_register_bank u_angle_sensor_register_bank (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
		.miso_oe_n_o(oe_n), .angle_raw_i(ang_raw), .flux_raw_i(flux),
		.flux_fault_i(flux_flt), .track_loss_i(trk_loss), .nvm_zero_point_i(nvm_zp),
		.nvm_inc_cfg_i(12'h000), .nvm_dis_i(12'h000), .nvm_uvw_i(12'h052),
		.nvm_lock_i(12'h003), .angle_o(ang), .position_o(), .user_mode_o(um),
		.zero_point_offset_o(zp), .incremental_output_config_o(inc_cfg),
		.commutation_output_config_o(uvw_cfg), .fault_detect_disable_o(dis_cfg));
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	task automatic wrap_up;
		if (exp_q.size() != 0) error_cnt++;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Register changes land a few system cycles after the last data bit, before chip select rises
	task automatic wr(input logic [3:0] op, input logic [6:0] a, input logic [11:0] v);
		u_spi_host_model.xfer(op, a, v);
		repeat (6) @(negedge clk_sys_i);
	endtask
	task automatic rd(input logic [6:0] a, input logic [11:0] e);
		exp_q.push_back(e);
		u_spi_host_model.xfer(OP_READ, a, 12'h000);
	endtask
	initial begin
		#1;
		forever begin
			@(done);
			tmp = exp_q.pop_front();
			`CHK("read", tmp, word)
		end
	end
	initial begin
		#1_000_000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		seed = 36;
		rst_i = 1'b1;
		flux_flt = 1'b1;
		trk_loss = 1'b0;
		ang_raw = 12'h000;
		flux = 7'h00;
		nvm_zp = 12'h0123;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		{flux, ang_raw} <= 19'($random(seed));
		repeat (5) @(negedge clk_sys_i);
		`CHK("zero", nvm_zp, zp)
		rd(ADDR_ANGLE, ang_raw);
		rd(ADDR_FLUX, 12'h000);
		wr(OP_WRITE, ADDR_ZERO, 12'h0ABC);
		wr(OP_MODE, ADDR_MODE, 12'h0123);
		`CHK("mode", 1'b0, um)
		`CHK("zero", nvm_zp, zp)
		wr(OP_MODE, ADDR_MODE, MODE_USER);
		`CHK("mode", 1'b1, um)
		wr(OP_WRITE, ADDR_MODE, MODE_NORMAL);
		`CHK("mode", 1'b1, um)
		rd(ADDR_FLUX, {5'h00, flux});
		rd(ADDR_FAULT, 12'h001);
		wr(OP_WRITE, ADDR_LOCK, 12'h0000);
		rd(ADDR_LOCK, 12'h003);
		wr(OP_WRITE, 7'h04, 12'hFFF);
		rd(7'h04, 12'h000);
		for (int i = 6; i <= 10; i++) if (i != 8) begin
			d = 12'($random(seed));
			wr(OP_WRITE, 7'(i), d);
			rd(7'(i), d);
		end
		`CHK("uvw", d, uvw_cfg)
		wr(OP_WRITE, ADDR_DIS, 12'h003);
		`CHK("dis", 12'h003, dis_cfg)
		rd(ADDR_FAULT, 12'h003);
		wr(OP_WRITE, ADDR_INC, 12'h040);
		`CHK("inc", 12'h040, inc_cfg)
		d = ang_raw;
		@(posedge clk_sys_i);
		ang_raw <= d + 12'h003;
		repeat (6) @(negedge clk_sys_i);
		`CHK("angle", d, ang)
		@(posedge clk_sys_i);
		ang_raw <= d + 12'h008;
		repeat (6) @(negedge clk_sys_i);
		`CHK("angle", d + 12'h008, ang)
		wr(OP_MODE, ADDR_MODE, MODE_NORMAL);
		`CHK("mode", 1'b0, um)
		`CHK("zero", nvm_zp, zp)
		repeat (4) @(negedge clk_sys_i);
		wrap_up();
	end
endmodule
`default_nettype wire
